// ===== verilog/prmc_top.sv
`timescale 1ns/10ps
`default_nettype none
module prmc_top
  import prmc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic idle_instr_in,
  input wire logic deep_sleep_instruction_in,
  input wire logic bus_busy_in,
  input wire logic bus_ready_seen_in,
  input wire logic irq_request_in,
  input wire logic nmi_pin_n_in,
  input wire logic reset_input_pin_n_in,
  input wire logic [7:0] fast_ext_irq_pin_in,
  input wire logic [7:0] fast_irq_enable_in,
  input wire logic [7:0] fast_irq_rising_in,
  input wire logic rtc_irq_in,
  input wire logic can_wake_in,
  input wire logic i2c_wake_in,
  input wire logic lpo_running_in,
  input wire logic main_supply_ok_in,
  output logic cpu_halt_out,
  output logic periph_clk_en_out,
  output logic watchdog_hold_out,
  output logic main_osc_en_out,
  output logic rtc_ref_lpo_out,
  output logic rtc_clk_en_out,
  output logic retained_ram_en_out,
  output logic ram_freeze_out,
  output logic wake_irq_out,
  output logic sleep_refused_out
);
  prmc_state_t state;
  prmc_state_t next_state;
  logic [31:0] ctrl;
  logic [31:0] system_config_register;
  logic [31:0] misc_extension_register;
  logic [31:0] extension_peripheral_config_register;
  logic lpo_adopted;
  logic pend_idle;
  logic pend_deep;
  logic deep_variant;
  logic refused_flag;
  logic [2:0] restart_cnt;
  logic aw_hold;
  logic w_hold;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  prmc_wake_if wk();

  assign wk.pin = fast_ext_irq_pin_in;
  assign wk.enable = fast_irq_enable_in;
  assign wk.active_high = fast_irq_rising_in;

  prmc_wake_filter u_filt (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .w(wk.filt)
  );

  // Register write path
  wire do_write = aw_hold & w_hold & ~s_axi_bvalid;
  wire wr_ctrl = do_write & (aw_addr == ADDR_CTRL);
  wire wr_sys = do_write & (aw_addr == ADDR_SYSCFG);
  wire wr_misc = do_write & (aw_addr == ADDR_MISC);
  wire wr_xper = do_write & (aw_addr == ADDR_XPER);
  wire wr_ok = wr_ctrl | wr_sys | wr_misc | wr_xper;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] status_word = {26'h0, refused_flag, lpo_adopted,
                             state, 1'b0} | 32'(main_osc_en_out) << 7;
  wire [31:0] rd_mux =
    (s_axi_araddr == ADDR_CTRL) ? ctrl :
    (s_axi_araddr == ADDR_SYSCFG) ? system_config_register :
    (s_axi_araddr == ADDR_MISC) ? misc_extension_register :
    (s_axi_araddr == ADDR_XPER) ? extension_peripheral_config_register :
    (s_axi_araddr == ADDR_STATUS) ? status_word : 32'h0;
  wire rd_ok = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_SYSCFG) |
    (s_axi_araddr == ADDR_MISC) | (s_axi_araddr == ADDR_XPER) |
    (s_axi_araddr == ADDR_STATUS);
  wire variant_irq = system_config_register[SYSCFG_VARIANT_BIT];

  // Sleep request checks
  wire any_enabled_active = |wk.active;
  wire rdy_fail = ctrl[CTRL_RDY_EN_BIT] & ~bus_ready_seen_in;
  wire deep_allowed = deep_variant ? ~any_enabled_active
                                  : ~nmi_pin_n_in;
  wire deep_wake = reset_input_pin_n_in == 1'b0 ? 1'b1 :
    deep_variant & ((|wk.held) | rtc_irq_in | can_wake_in |
    i2c_wake_in);
  wire in_deep = (state == PRMC_DEEP);
  wire rtc_on = ctrl[CTRL_RTC_EN_BIT];
  wire use_lpo = lpo_adopted & ~ctrl[CTRL_LPO_DIS_BIT];

  always_comb begin
    next_state = state;
    case (state)
      PRMC_RUN: begin
        if (idle_instr_in | deep_sleep_instruction_in) begin
          next_state = PRMC_DRAIN;
        end
      end
      PRMC_DRAIN: begin
        if (!bus_busy_in) begin
          if (rdy_fail) begin
            next_state = PRMC_RUN;
          end else if (pend_idle) begin
            next_state = PRMC_IDLE;
          end else if (pend_deep && deep_allowed) begin
            next_state = PRMC_DEEP;
          end else begin
            next_state = PRMC_RUN;
          end
        end
      end
      PRMC_IDLE: begin
        if (irq_request_in) begin
          next_state = PRMC_RUN;
        end
      end
      PRMC_DEEP: begin
        if (deep_wake) begin
          next_state = PRMC_RESTART;
        end
      end
      PRMC_RESTART: begin
        if (restart_cnt >= RESTART_CYC3) begin
          next_state = PRMC_RUN;
        end
      end
      default: next_state = PRMC_RUN;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state <= PRMC_RUN;
      pend_idle <= 1'b0;
      pend_deep <= 1'b0;
      deep_variant <= 1'b0;
      restart_cnt <= 3'h0;
      refused_flag <= 1'b0;
    end else begin
      state <= next_state;
      if (state == PRMC_RUN) begin
        pend_idle <= idle_instr_in;
        pend_deep <= deep_sleep_instruction_in & ~idle_instr_in;
        deep_variant <= variant_irq;
      end
      restart_cnt <= (state == PRMC_RESTART) ? restart_cnt + 3'h1 : 3'h0;
      if (state == PRMC_DRAIN && next_state == PRMC_RUN) begin
        refused_flag <= 1'b1;
      end else if (next_state == PRMC_IDLE || next_state == PRMC_DEEP) begin
        refused_flag <= 1'b0;
      end
    end
  end

  // Low-power oscillator adoption, kept until software disables it
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      lpo_adopted <= 1'b0;
    end else if (ctrl[CTRL_LPO_DIS_BIT]) begin
      lpo_adopted <= 1'b0;
    end else if (lpo_running_in) begin
      lpo_adopted <= 1'b1;
    end
  end

  // Registers; retained RAM enable cleared by sys_rst_in only, not by the reset pin
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctrl <= 32'h0;
      system_config_register <= 32'h0;
      misc_extension_register <= 32'h0;
      extension_peripheral_config_register <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= (ctrl & ~wmask) | (w_data & wmask);
      end
      if (wr_sys) begin
        system_config_register <= (system_config_register & ~wmask) |
          (w_data & wmask);
      end
      if (wr_misc) begin
        misc_extension_register <= (misc_extension_register & ~wmask) |
          (w_data & wmask);
      end
      if (wr_xper) begin
        extension_peripheral_config_register <=
          (extension_peripheral_config_register & ~wmask) |
          (w_data & wmask);
      end
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 12'h0;
      w_data <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Clock and power outputs
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cpu_halt_out <= 1'b0;
      periph_clk_en_out <= 1'b1;
      watchdog_hold_out <= 1'b0;
      main_osc_en_out <= 1'b1;
      rtc_ref_lpo_out <= 1'b0;
      rtc_clk_en_out <= 1'b0;
      retained_ram_en_out <= 1'b0;
      ram_freeze_out <= 1'b1;
      wake_irq_out <= 1'b0;
      sleep_refused_out <= 1'b0;
    end else begin
      cpu_halt_out <= (next_state != PRMC_RUN) &
                      (next_state != PRMC_DRAIN);
      periph_clk_en_out <= (next_state != PRMC_DEEP) &
                           (next_state != PRMC_RESTART);
      watchdog_hold_out <= (next_state == PRMC_DEEP) |
                           (next_state == PRMC_RESTART);
      main_osc_en_out <= main_supply_ok_in &
        ~((next_state == PRMC_DEEP) & use_lpo);
      rtc_ref_lpo_out <= use_lpo;
      rtc_clk_en_out <= rtc_on & (use_lpo | main_supply_ok_in);
      retained_ram_en_out <= main_supply_ok_in &
        extension_peripheral_config_register[XPER_RAMEN_BIT];
      ram_freeze_out <= ~main_supply_ok_in |
        ~extension_peripheral_config_register[XPER_RAMEN_BIT];
      wake_irq_out <= (state == PRMC_RESTART) &
                      (next_state == PRMC_RUN);
      sleep_refused_out <= refused_flag;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/prmc_pkg.sv
// Contract
// - Sleep entered only by protected CPU instruction; idle or deep sleep selected.
// - Idle halts only CPU execution; peripherals stay clocked.
// - Any interrupt ends idle; execution resumes after the halt instruction.
// - Deep sleep stops internal clock and watchdog; only RTC and reference run.
// - Pending external bus transactions finish before idle or deep sleep.
// - Refuse sleep if ready handshake enabled but not seen at last access.
// - Running low-power oscillator becomes RTC reference; main oscillator stops in deep sleep.
// - With only main oscillator, it keeps running in deep sleep for RTC.
// - Bit 5 of system config selects variant: 0 protected, 1 interruptible.
// - Protected deep sleep entered only when NMI pin is low.
// - Protected deep sleep left only by external reset pin.
// - Interruptible deep sleep entered only if enabled fast irq pins inactive.
// - Interruptible sleep left by reset, fast irq, RTC, CAN or I2C wake.
// - In reset, retained RAM is disabled and its interface frozen.
// - Stand-by keeps only retained RAM, RTC counters and low-power oscillator.
// - Retained RAM stays frozen after power-on until software sets enable.
// - RTC keeps counting in stand-by only with low-power oscillator reference.
package prmc_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_SYSCFG = 12'h004;
  localparam logic [11:0] ADDR_MISC = 12'h008;
  localparam logic [11:0] ADDR_XPER = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam int SYSCFG_VARIANT_BIT = 5;
  localparam int MISC_REGOFF_BIT = 0;
  localparam int XPER_RAMEN_BIT = 0;
  localparam int CTRL_RTC_EN_BIT = 0;
  localparam int CTRL_LPO_DIS_BIT = 1;
  localparam int CTRL_RDY_EN_BIT = 2;
  localparam int CTRL_RDY_POL_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_MHZ = 100;
  localparam int WAKE_MIN_NS = 40;
  localparam int WAKE_CYC = (WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] WAKE_CYC3 = 3'(WAKE_CYC);
  localparam int RESTART_CYC = 4;
  localparam logic [2:0] RESTART_CYC3 = 3'(RESTART_CYC);
  typedef enum logic [2:0] {
    PRMC_RUN = 3'h0,
    PRMC_DRAIN = 3'h1,
    PRMC_IDLE = 3'h3,
    PRMC_DEEP = 3'h2,
    PRMC_RESTART = 3'h6
  } prmc_state_t;
endpackage

// ===== verilog/prmc_wake_if.sv
`timescale 1ns/10ps
`default_nettype none
interface prmc_wake_if;
  logic [7:0] pin;
  logic [7:0] enable;
  logic [7:0] active_high;
  wire logic [7:0] active;
  wire logic [7:0] held;
  modport filt (input pin, enable, active_high, output active, held);
  modport ctrl (output pin, enable, active_high, input active, held);
endinterface
`default_nettype wire

// ===== verilog/prmc_wake_filter.sv
`timescale 1ns/10ps
`default_nettype none
module prmc_wake_filter
  import prmc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  prmc_wake_if.filt w
);
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_ch
      logic [2:0] cnt;
      wire lvl = w.enable[i] & (w.pin[i] ~^ w.active_high[i]);
      assign w.active[i] = lvl;
      assign w.held[i] = (cnt >= WAKE_CYC3);
      // Pulses shorter than the minimum width are ignored
      always_ff @(posedge mclk_in) begin
        if (sys_rst_in || !lvl) begin
          cnt <= 3'h0;
        end else if (cnt < WAKE_CYC3) begin
          cnt <= cnt + 3'h1;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== verif/prmc_properties.sv
`timescale 1ns/10ps
`default_nettype none
module prmc_properties (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic bus_busy_in,
  input wire logic irq_request_in,
  input wire logic reset_input_pin_n_in,
  input wire logic main_supply_ok_in,
  input wire logic cpu_halt_out,
  input wire logic periph_clk_en_out,
  input wire logic watchdog_hold_out,
  input wire logic main_osc_en_out,
  input wire logic rtc_ref_lpo_out,
  input wire logic rtc_clk_en_out,
  input wire logic retained_ram_en_out,
  input wire logic ram_freeze_out,
  input wire logic wake_irq_out,
  input wire logic sleep_refused_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  sequence in_idle;
    cpu_halt_out && periph_clk_en_out;
  endsequence
  sequence in_sleep;
    cpu_halt_out && !periph_clk_en_out;
  endsequence
  wd_pair_a: assert property (watchdog_hold_out == !periph_clk_en_out)
    else $error("watchdog hold differs from clock stop");
  entry_drain_a: assert property ($rose(cpu_halt_out) |-> !$past(bus_busy_in))
    else $error("sleep entered with bus busy");
  run_clock_a: assert property (!cpu_halt_out |-> periph_clk_en_out)
    else $error("peripherals stopped while running");
  idle_wake_a: assert property (in_idle ##0 irq_request_in |=> !cpu_halt_out)
    else $error("idle not ended by interrupt");
  pin_wake_a: assert property (in_sleep ##0 !reset_input_pin_n_in
    |-> ##[1:8] wake_irq_out) else $error("reset pin did not wake");
  wake_run_a: assert property ($rose(wake_irq_out) |-> periph_clk_en_out
    && !cpu_halt_out && !$past(periph_clk_en_out)) else $error("bad resume");
  wake_pulse_a: assert property (wake_irq_out |=> !wake_irq_out)
    else $error("wake pulse too long");
  refuse_awake_a: assert property ($rose(sleep_refused_out) |-> !cpu_halt_out)
    else $error("refused yet halted");
  supply_freeze_a: assert property (!main_supply_ok_in |=> ram_freeze_out
    && !retained_ram_en_out) else $error("ram not frozen");
  standby_rtc_a: assert property (!main_supply_ok_in ##1 !main_supply_ok_in
    |-> !rtc_clk_en_out || rtc_ref_lpo_out) else $error("rtc ran on main osc");
  osc_keep_a: assert property (!main_osc_en_out && main_supply_ok_in
    && $past(main_supply_ok_in) |-> rtc_ref_lpo_out) else $error("osc stopped");
endmodule
`default_nettype wire

// ===== verif/prmc_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module prmc_far_model (
  input wire logic mclk_in,
  input wire logic [7:0] pol_in,
  output logic [7:0] pins_out,
  output logic rst_n_out,
  output logic supply_out
);
  logic [7:0] hit = 8'h00;
  logic rst_n = 1'b1;
  logic sup = 1'b1;
  // Pins sit at inactive level unless asserted
  assign pins_out = hit ^ ~pol_in;
  assign rst_n_out = rst_n;
  assign supply_out = sup;
  task automatic hold_pin(input int idx, input int n);
    hit[idx] <= 1'b1;
    repeat (n) @(posedge mclk_in);
    hit[idx] <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic reset_pin(input int n);
    rst_n <= 1'b0;
    repeat (n) @(posedge mclk_in);
    rst_n <= 1'b1;
    @(posedge mclk_in);
  endtask
  task automatic standby(input int n);
    rst_n <= 1'b0;
    @(posedge mclk_in);
    sup <= 1'b0;
    repeat (n) @(posedge mclk_in);
    sup <= 1'b1;
    @(posedge mclk_in);
    rst_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== verif/test_power_reduction_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_power_reduction_mode_control
  import prmc_pkg::*;
;
  logic mclk_in, sys_rst_in = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic idle_instr_in = 0, deep_sleep_instruction_in = 0, bus_busy_in = 0;
  logic bus_ready_seen_in = 1, irq_request_in = 0, nmi_pin_n_in = 1;
  logic rtc_irq_in = 0, can_wake_in = 0, i2c_wake_in = 0, lpo_running_in = 0;
  logic reset_input_pin_n_in, main_supply_ok_in;
  logic [7:0] fast_ext_irq_pin_in, fast_irq_enable_in = 0, fast_irq_rising_in = 0;
  logic cpu_halt_out, periph_clk_en_out, watchdog_hold_out, main_osc_en_out;
  logic rtc_ref_lpo_out, rtc_clk_en_out, retained_ram_en_out, ram_freeze_out;
  logic wake_irq_out, sleep_refused_out;
  logic [33:0] exp_q[$];
  int checks = 0, mismatches = 0, cyc = 0, idx;
  prmc_top i_dut (.*);
  prmc_far_model i_far (.mclk_in(mclk_in), .pol_in(fast_irq_rising_in),
    .pins_out(fast_ext_irq_pin_in), .rst_n_out(reset_input_pin_n_in),
    .supply_out(main_supply_ok_in));
  initial begin
    mclk_in = 0;
    forever #5 mclk_in = ~mclk_in;
  end
  task final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic a, input logic e);
    checks++;
    if (a !== e) begin
      mismatches++;
      $display("unexpected at %0t: output level", $time);
    end
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      final_report;
    end
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      checks++;
      if (exp_q.size() == 0 || exp_q.pop_front() !== (s_axi_rvalid ?
          {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0})) begin
        mismatches++;
        $display("unexpected at %0t: bus answer", $time);
      end
    end
  end
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] r);
    bit ga = 0;
    bit gd = 0;
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ga && gd)) begin
      @(posedge mclk_in);
      ga = ga | s_axi_awready;
      gd = gd | s_axi_wready;
      if (ga) s_axi_awvalid <= 1'b0;
      if (gd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge mclk_in); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] r);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk_in); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk_in); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic sleep(input bit deep);
    if (deep) deep_sleep_instruction_in <= 1'b1;
    else idle_instr_in <= 1'b1;
    @(posedge mclk_in);
    deep_sleep_instruction_in <= 1'b0;
    idle_instr_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
  endtask
  initial begin
    void'($urandom(32'h4896FDC6));
    idx = $urandom_range(0, 7);
    repeat (4) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    fast_irq_enable_in <= 8'h01 << idx;
    fast_irq_rising_in <= 8'($urandom());
    @(posedge mclk_in);
    chk(ram_freeze_out, 1'b1);
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    axr(12'h020, 32'h0, RESP_SLVERR);
    axw(12'h020, 32'hFFFFFFFF, RESP_SLVERR);
    bus_busy_in <= 1'b1;
    sleep(0);
    repeat ($urandom_range(1, 5)) @(posedge mclk_in);
    chk(cpu_halt_out, 1'b0);
    bus_busy_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk(cpu_halt_out, 1'b1);
    chk(periph_clk_en_out, 1'b1);
    irq_request_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    irq_request_in <= 1'b0;
    chk(cpu_halt_out, 1'b0);
    axw(ADDR_CTRL, 32'h4, RESP_OKAY);
    bus_ready_seen_in <= 1'b0;
    sleep(0);
    chk(sleep_refused_out, 1'b1);
    bus_ready_seen_in <= 1'b1;
    axw(ADDR_MISC, 32'h1, RESP_OKAY);
    axw(ADDR_CTRL, 32'h1, RESP_OKAY);
    sleep(1);
    chk(cpu_halt_out, 1'b0);
    nmi_pin_n_in <= 1'b0;
    sleep(1);
    chk(watchdog_hold_out, 1'b1);
    chk(sleep_refused_out, 1'b0);
    chk(main_osc_en_out, 1'b1);
    rtc_irq_in <= 1'b1;
    i_far.hold_pin(idx, 6);
    rtc_irq_in <= 1'b0;
    chk(cpu_halt_out, 1'b1);
    i_far.reset_pin(2);
    repeat (8) @(posedge mclk_in);
    chk(cpu_halt_out, 1'b0);
    nmi_pin_n_in <= 1'b1;
    axw(ADDR_SYSCFG, 32'h20, RESP_OKAY);
    axr(ADDR_SYSCFG, 32'h20, RESP_OKAY);
    fork
      i_far.hold_pin(idx, 8);
      sleep(1);
    join
    chk(sleep_refused_out, 1'b1);
    sleep(1);
    i_far.hold_pin(idx, 2);
    chk(cpu_halt_out, 1'b1);
    i_far.hold_pin(idx, 5);
    repeat (8) @(posedge mclk_in);
    chk(cpu_halt_out, 1'b0);
    for (int k = 0; k < 3; k++) begin
      sleep(1);
      {rtc_irq_in, can_wake_in, i2c_wake_in} <= 3'h1 << k;
      @(posedge mclk_in);
      {rtc_irq_in, can_wake_in, i2c_wake_in} <= 3'h0;
      repeat (8) @(posedge mclk_in);
      chk(cpu_halt_out, 1'b0);
    end
    lpo_running_in <= 1'b1;
    sleep(1);
    chk(rtc_ref_lpo_out, 1'b1);
    chk(main_osc_en_out, 1'b0);
    i_far.reset_pin(2);
    repeat (8) @(posedge mclk_in);
    axw(ADDR_XPER, 32'h1, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      axw(ADDR_CTRL, 32'(1 + 2 * i), RESP_OKAY);
      fork
        i_far.standby(8);
        begin
          repeat (5) @(posedge mclk_in);
          chk(rtc_clk_en_out, i == 0);
          chk(ram_freeze_out, 1'b1);
        end
      join
    end
    sys_rst_in <= 1'b1;
    i_far.standby(4);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk(ram_freeze_out, 1'b1);
    axw(ADDR_XPER, 32'h1, RESP_OKAY);
    repeat (2) @(posedge mclk_in);
    chk(retained_ram_en_out, 1'b1);
    final_report;
  end
endmodule
bind prmc_top prmc_properties i_chk (.*);
`default_nettype wire
